// [design/mcsd_top.sv]
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - switches 1,2: both off ignore, 1 off 2 on real-time, both on latched.
// - ignore mode never disables output, whatever the shutdown line does.
// - latched mode disables output on assertion until software restore command.
// - real-time mode disables output only while the line is low.
// - shutdown line idles high; low, including outside contact closure, is asserted.
// - switch 3 off forces readouts dark; on lets software control them.
// - switches 4,5: both off inhibit, 4 off 5 on factory, both on normal.
// - normal needs password; factory restores without password; inhibit rejects all.
// - power-up: switch 6 on gives reset state, else recall slot 0.
// - closed switch reads 1; defaults latched, display on, normal cal, reset state.
module mcsd_top
    import mcsd_pkg::*;
(
    input  wire logic                       clock_in,
    input  wire logic                       rst_in,
    input  wire logic [mcsd_pkg::SW_WIDTH-1:0] config_switch_in,
    input  wire logic                       shared_shutdown_line_in,
    input  wire logic                       restore_cmd_in,
    input  wire logic                       display_cmd_on_in,
    input  wire logic                       display_cmd_off_in,
    input  wire logic                       cal_request_in,
    input  wire logic                       cal_password_ok_in,
    input  wire logic                       cal_factory_request_in,
    output logic                            output_enable_out,
    output logic                            shutdown_latched_out,
    output logic [1:0]                      shutdown_mode_out,
    output logic [1:0]                      cal_mode_out,
    output logic                            readout_enable_out,
    output logic                            annunciator_enable_out,
    output logic                            cal_accept_out,
    output logic                            cal_factory_restore_out,
    output logic                            cal_reject_out,
    output logic                            power_on_valid_out,
    output logic                            power_on_reset_out,
    output logic                            power_on_recall_out,
    output logic [3:0]                      recall_slot_out,
    output logic                            service_fault_out
);

    import mcsd_pkg::*;

    // ==========================================
    // Input synchronisers
    logic [SW_WIDTH-1:0] sw;
    logic                line_high;

    mcsd_sync #(
        .WIDTH (SW_WIDTH),
        .INIT  (SW_DEFAULT)
    ) u_sw_sync (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .async_in (config_switch_in),
        .sync_out (sw)
    );

    // Line idles high, so reset value is the idle level
    mcsd_sync #(
        .WIDTH (1),
        .INIT  (1'b1)
    ) u_line_sync (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .async_in (shared_shutdown_line_in),
        .sync_out (line_high)
    );

    // ==========================================
    // Decode
    wire       shut_asserted = ~line_high;
    wire [1:0] shut_decode   = (!sw[SW_SHUT_A] &&  sw[SW_SHUT_B]) ? SHUT_REALTIME :
                               ( sw[SW_SHUT_A] &&  sw[SW_SHUT_B]) ? SHUT_LATCHED  :
                               SHUT_IGNORE;
    wire [1:0] cal_decode    = (!sw[SW_CAL_A] &&  sw[SW_CAL_B]) ? CAL_FACTORY :
                               ( sw[SW_CAL_A] &&  sw[SW_CAL_B]) ? CAL_NORMAL  :
                               CAL_INHIBIT;
    wire       display_allowed = sw[SW_DISPLAY];
    wire       service_ok      = sw[SW_SERVICE_A] & sw[SW_SERVICE_B];

    // ==========================================
    // Latched shutdown; assertion wins over a coincident restore
    logic latch_set;
    logic next_latch;

    assign latch_set  = (shut_decode == SHUT_LATCHED) && shut_asserted;
    assign next_latch = latch_set ? 1'b1 :
                        restore_cmd_in ? 1'b0 :
                        (shut_decode == SHUT_LATCHED) ? latch_set | shutdown_latched_out : 1'b0;

    wire next_out_en = (shut_decode == SHUT_IGNORE)   ? 1'b1 :
                       (shut_decode == SHUT_REALTIME) ? ~shut_asserted :
                       ~next_latch;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            shutdown_latched_out <= 1'b0;
            output_enable_out    <= 1'b1;
        end else begin
            shutdown_latched_out <= next_latch;
            output_enable_out    <= next_out_en;
        end
    end

    // ==========================================
    // Readout enable under software control
    logic sw_display_on;
    wire  next_sw_display = display_cmd_on_in  ? 1'b1 :
                            display_cmd_off_in ? 1'b0 : sw_display_on;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            sw_display_on          <= 1'b1;
            readout_enable_out     <= 1'b0;
            annunciator_enable_out <= 1'b0;
        end else begin
            sw_display_on          <= next_sw_display;
            readout_enable_out     <= display_allowed & next_sw_display;
            annunciator_enable_out <= 1'b1;
        end
    end

    // ==========================================
    // Calibration gate; one-cycle answers to one-cycle requests
    wire next_accept  = cal_request_in && (cal_decode == CAL_NORMAL) && cal_password_ok_in;
    wire next_factory = cal_factory_request_in && (cal_decode == CAL_FACTORY);
    wire next_reject  = (cal_request_in && !next_accept) ||
                        (cal_factory_request_in && !next_factory);

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cal_accept_out          <= 1'b0;
            cal_factory_restore_out <= 1'b0;
            cal_reject_out          <= 1'b0;
            cal_mode_out            <= CAL_INHIBIT;
            shutdown_mode_out       <= SHUT_IGNORE;
            service_fault_out       <= 1'b0;
        end else begin
            cal_accept_out          <= next_accept;
            cal_factory_restore_out <= next_factory;
            cal_reject_out          <= next_reject;
            cal_mode_out            <= cal_decode;
            shutdown_mode_out       <= shut_decode;
            service_fault_out       <= ~service_ok;
        end
    end

    // ==========================================
    // Power-on choice, taken once after the synchroniser has settled;
    // later switch moves do not matter until the next reset
    logic [2:0] settle;
    wire        settle_done = (settle == 3'(SETTLE_CYCLES));

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            settle              <= 3'h0;
            power_on_valid_out  <= 1'b0;
            power_on_reset_out  <= 1'b0;
            power_on_recall_out <= 1'b0;
            recall_slot_out     <= RECALL_SLOT;
        end else if (!settle_done) begin
            settle <= settle + 3'h1;
        end else if (!power_on_valid_out) begin
            power_on_valid_out  <= 1'b1;
            power_on_reset_out  <= sw[SW_POWER_ON];
            power_on_recall_out <= ~sw[SW_POWER_ON];
            recall_slot_out     <= RECALL_SLOT;
        end
    end

    // ==========================================
    // Checks
    sequence line_drops_s;
        $fell(line_high);
    endsequence

    sequence held_off_s;
        !output_enable_out [*3];
    endsequence

    // Settle counter plus one register stage before the choice shows
    sequence settle_wait_s;
        !power_on_valid_out [*5];
    endsequence

    ignore_mode_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (shut_decode == SHUT_IGNORE) ##1 (shut_decode == SHUT_IGNORE) |-> output_enable_out)
        else $error("output dropped in ignore mode");

    latch_hold_a: assert property (@(posedge clock_in) disable iff (rst_in)
        shutdown_latched_out && !restore_cmd_in && (shut_decode == SHUT_LATCHED)
        |=> shutdown_latched_out && !output_enable_out)
        else $error("latched shutdown released without restore");

    latch_set_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (shut_decode == SHUT_LATCHED) ##0 line_drops_s ##0 $stable(shut_decode)
        |=> held_off_s or (##[0:2] restore_cmd_in))
        else $error("latched shutdown not held");

    realtime_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (shut_decode == SHUT_REALTIME) |=> (shut_decode != SHUT_REALTIME) ||
        (output_enable_out == $past(line_high)))
        else $error("real-time output does not follow line");

    readout_dark_a: assert property (@(posedge clock_in) disable iff (rst_in)
        !display_allowed |=> !readout_enable_out)
        else $error("readout lit with display switch off");

    cal_inhibit_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (cal_decode == CAL_INHIBIT) && (cal_request_in || cal_factory_request_in)
        |=> cal_reject_out && !cal_accept_out && !cal_factory_restore_out)
        else $error("calibration taken while inhibited");

    cal_password_a: assert property (@(posedge clock_in) disable iff (rst_in)
        cal_accept_out |-> $past(cal_password_ok_in) && ($past(cal_decode) == CAL_NORMAL))
        else $error("calibration accepted without password");

    power_on_a: assert property (@(posedge clock_in) disable iff (rst_in)
        $rose(power_on_valid_out) |-> (power_on_reset_out == $past(sw[SW_POWER_ON]))
        && (power_on_recall_out != power_on_reset_out) && (recall_slot_out == RECALL_SLOT))
        else $error("wrong power-on choice");

    decode_map_a: assert property (@(posedge clock_in) disable iff (rst_in)
        sw[SW_SHUT_A] && !sw[SW_SHUT_B] |=> shutdown_mode_out == SHUT_IGNORE)
        else $error("undocumented shutdown setting not ignored");

    realtime_off_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (shut_decode == SHUT_REALTIME) && shut_asserted |=> !output_enable_out && !shutdown_latched_out)
        else $error("real-time output not off while line low");

    realtime_back_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (shut_decode == SHUT_REALTIME) && line_high |=> output_enable_out)
        else $error("real-time output not back with line high");

    no_latch_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (shut_decode != SHUT_LATCHED) |=> !shutdown_latched_out)
        else $error("shutdown latched outside latched mode");

    restore_clear_a: assert property (@(posedge clock_in) disable iff (rst_in)
        shutdown_latched_out && restore_cmd_in && line_high && (shut_decode == SHUT_LATCHED)
        |=> !shutdown_latched_out && output_enable_out)
        else $error("restore did not clear latched shutdown");

    latch_enter_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (shut_decode == SHUT_LATCHED) && shut_asserted |=> shutdown_latched_out && !output_enable_out)
        else $error("low line not taken as shutdown");

    readout_on_a: assert property (@(posedge clock_in) disable iff (rst_in)
        display_allowed && display_cmd_on_in |=> readout_enable_out)
        else $error("readout not lit by software");

    readout_off_a: assert property (@(posedge clock_in) disable iff (rst_in)
        display_cmd_off_in && !display_cmd_on_in |=> !readout_enable_out)
        else $error("readout not darkened by software");

    annunciator_a: assert property (@(posedge clock_in) disable iff (rst_in)
        !rst_in |=> annunciator_enable_out)
        else $error("annunciators dropped");

    factory_restore_a: assert property (@(posedge clock_in) disable iff (rst_in)
        cal_factory_request_in && !cal_request_in && (cal_decode == CAL_FACTORY)
        |=> cal_factory_restore_out && !cal_reject_out)
        else $error("factory restore refused in factory mode");

    cal_nopass_a: assert property (@(posedge clock_in) disable iff (rst_in)
        cal_request_in && !cal_password_ok_in |=> cal_reject_out && !cal_accept_out)
        else $error("calibration without password not rejected");

    accept_pulse_a: assert property (@(posedge clock_in) disable iff (rst_in)
        cal_accept_out && !cal_request_in |=> !cal_accept_out)
        else $error("accept pulse longer than one cycle");

    shut_latched_map_a: assert property (@(posedge clock_in) disable iff (rst_in)
        sw[SW_SHUT_A] && sw[SW_SHUT_B] |=> shutdown_mode_out == SHUT_LATCHED)
        else $error("latched setting misread");

    shut_realtime_map_a: assert property (@(posedge clock_in) disable iff (rst_in)
        !sw[SW_SHUT_A] && sw[SW_SHUT_B] |=> shutdown_mode_out == SHUT_REALTIME)
        else $error("real-time setting misread");

    shut_ignore_map_a: assert property (@(posedge clock_in) disable iff (rst_in)
        !sw[SW_SHUT_A] && !sw[SW_SHUT_B] |=> shutdown_mode_out == SHUT_IGNORE)
        else $error("ignore setting misread");

    cal_normal_map_a: assert property (@(posedge clock_in) disable iff (rst_in)
        sw[SW_CAL_A] && sw[SW_CAL_B] |=> cal_mode_out == CAL_NORMAL)
        else $error("normal calibration setting misread");

    cal_factory_map_a: assert property (@(posedge clock_in) disable iff (rst_in)
        !sw[SW_CAL_A] && sw[SW_CAL_B] |=> cal_mode_out == CAL_FACTORY)
        else $error("factory calibration setting misread");

    cal_inhibit_map_a: assert property (@(posedge clock_in) disable iff (rst_in)
        !sw[SW_CAL_A] && !sw[SW_CAL_B] |=> cal_mode_out == CAL_INHIBIT)
        else $error("inhibit calibration setting misread");

    cal_odd_map_a: assert property (@(posedge clock_in) disable iff (rst_in)
        sw[SW_CAL_A] && !sw[SW_CAL_B] |=> cal_mode_out == CAL_INHIBIT)
        else $error("undocumented calibration setting not inhibited");

    power_hold_a: assert property (@(posedge clock_in) disable iff (rst_in)
        power_on_valid_out |=> power_on_valid_out && $stable(power_on_reset_out) && $stable(power_on_recall_out))
        else $error("power-on choice changed before reset");

    power_delay_a: assert property (@(posedge clock_in) disable iff (rst_in)
        $fell(rst_in) |-> settle_wait_s ##1 power_on_valid_out)
        else $error("power-on choice not taken on time");

endmodule // mcsd_top

`default_nettype wire

// [design/mcsd_pkg.sv]
package mcsd_pkg;

    // ==========================================
    // Switch positions (bit index = position - 1)
    localparam int SW_WIDTH        = 8;
    localparam int SW_SHUT_A       = 0;
    localparam int SW_SHUT_B       = 1;
    localparam int SW_DISPLAY      = 2;
    localparam int SW_CAL_A        = 3;
    localparam int SW_CAL_B        = 4;
    localparam int SW_POWER_ON     = 5;
    localparam int SW_SERVICE_A    = 6;
    localparam int SW_SERVICE_B    = 7;

    // ==========================================
    // Shipped default switch word
    localparam logic [7:0] SW_DEFAULT = 8'hFF;

    // ==========================================
    // Encodings
    localparam logic [1:0] SHUT_IGNORE   = 2'h0;
    localparam logic [1:0] SHUT_REALTIME = 2'h1;
    localparam logic [1:0] SHUT_LATCHED  = 2'h2;

    localparam logic [1:0] CAL_INHIBIT   = 2'h0;
    localparam logic [1:0] CAL_FACTORY   = 2'h1;
    localparam logic [1:0] CAL_NORMAL    = 2'h2;

    localparam logic [1:0] PON_SAVED_SLOT = 2'h0;
    localparam logic [1:0] PON_RESET      = 2'h1;

    // ==========================================
    // Saved-state slot recalled at power-up
    localparam logic [3:0] RECALL_SLOT = 4'h0;

    // ==========================================
    // Cycles after reset release before switch word is captured
    localparam int SETTLE_CYCLES = 4;

endpackage : mcsd_pkg

// [design/mcsd_sync.sv]
`timescale 1ns/10ps
`default_nettype none

module mcsd_sync #(
    parameter int          WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             clock_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage;

    // ==========================================
    // Two-flop synchroniser; first stage feeds only the second
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            stage    <= INIT;
            sync_out <= INIT;
        end else begin
            stage    <= async_in;
            sync_out <= stage;
        end
    end

endmodule // mcsd_sync

`default_nettype wire

// [verif/mcsd_shutdown_partner.sv]
`timescale 1ns/10ps
`default_nettype none

module mcsd_shutdown_partner (
    input  wire logic contact_closed_in,
    output logic      line_out
);
    // ==========================================
    // Shared line
    // Pull-up keeps it high; a closed outside contact shorts it low
    assign line_out = contact_closed_in ? 1'b0 : 1'b1;
endmodule // mcsd_shutdown_partner

`default_nettype wire

// [verif/test_module_config_switch_decoder.sv]
`timescale 1ns/10ps
`default_nettype none

module test_module_config_switch_decoder;
    import mcsd_pkg::*;
    logic       clock_in = 0, rst_in = 1, contact = 0, restore = 0, don = 0, doff = 0;
    logic       creq = 0, cpw = 0, cfac = 0, line;
    logic [7:0] sw = SW_DEFAULT, lfsr = 8'h26;
    logic       oe, lat, ro, ann, acc, fac, rej, pv, prst, prcl, sflt;
    logic [1:0] smode, cmode;
    logic [3:0] slot;
    int         err_count = 0, cmp_count = 0;

    mcsd_shutdown_partner partner (.contact_closed_in(contact), .line_out(line));
    mcsd_top dut (.clock_in(clock_in), .rst_in(rst_in), .config_switch_in(sw), .shared_shutdown_line_in(line),
        .restore_cmd_in(restore), .display_cmd_on_in(don), .display_cmd_off_in(doff), .cal_request_in(creq),
        .cal_password_ok_in(cpw), .cal_factory_request_in(cfac), .output_enable_out(oe),
        .shutdown_latched_out(lat), .shutdown_mode_out(smode), .cal_mode_out(cmode), .readout_enable_out(ro),
        .annunciator_enable_out(ann), .cal_accept_out(acc), .cal_factory_restore_out(fac),
        .cal_reject_out(rej), .power_on_valid_out(pv), .power_on_reset_out(prst),
        .power_on_recall_out(prcl), .recall_slot_out(slot), .service_fault_out(sflt));

    initial forever #10 clock_in = ~clock_in;

    // ==========================================
    // Expectations
    function automatic logic [7:0] next_rand(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic logic [1:0] exp_shut(input logic [7:0] s);
        return s[1] ? (s[0] ? SHUT_LATCHED : SHUT_REALTIME) : SHUT_IGNORE;
    endfunction
    function automatic logic [1:0] exp_cal(input logic [7:0] s);
        return s[4] ? (s[3] ? CAL_NORMAL : CAL_FACTORY) : CAL_INHIBIT;
    endfunction

    // ==========================================
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        if (err_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wait_valid;
        int i;
        for (i = 0; i < 20 && pv !== 1'b1; i++) cyc(1);
        if (i == 20) begin
            err_count++;
            $display("Error power_on_valid expected 1 seen %b", pv);
            end_of_test();
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        cyc(1);
        s = 0;
        cyc(2);
    endtask
    // Answer stands only in the cycle after the request edge, so both cycles are looked at
    task automatic cal_try(input logic r, input logic f, input logic p, input logic [2:0] e);
        creq = r;
        cfac = f;
        cpw = p;
        cyc(1);
        creq = 0;
        cfac = 0;
        check("cal_pulses", {acc, fac, rej}, e);
        cyc(1);
        check("cal_idle", {acc, fac, rej}, 3'h0);
    endtask
    task automatic shut_case(input logic [7:0] s, input logic e_oe, input logic e_lat);
        sw = s;
        cyc(4);
        contact = 1;
        cyc(4);
        check("output_enable", oe, e_oe);
        check("shutdown_latched", lat, e_lat);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        cyc(10);
        rst_in = 0;
        wait_valid();
        check("power_on_reset", {prcl, prst}, 4'h1);
        check("annunciator", ann, 1'b1);
        check("defaults", {cmode, smode}, {CAL_NORMAL, SHUT_LATCHED});
        check("readout", ro, 1'b1);
        repeat (24) begin
            lfsr = next_rand(lfsr);
            sw = lfsr;
            cyc(4);
            check("shutdown_mode", smode, exp_shut(sw));
            check("cal_mode", cmode, exp_cal(sw));
            check("readout", ro, sw[2]);
            check("service_fault", sflt, ~&sw[7:6]);
            check("output_enable", oe, 1'b1);
        end
        // Service positions held closed from here on
        shut_case(8'hFC, 1'b1, 1'b0);
        contact = 0;
        shut_case(8'hFE, 1'b0, 1'b0);
        contact = 0;
        cyc(4);
        check("output_enable", oe, 1'b1);
        shut_case(8'hFF, 1'b0, 1'b1);
        pulse(restore);
        check("output_enable", oe, 1'b0);
        contact = 0;
        cyc(4);
        check("output_enable", oe, 1'b0);
        pulse(restore);
        check("restored", {lat, oe}, 4'h1);
        pulse(doff);
        check("readout", ro, 1'b0);
        pulse(don);
        check("readout", ro, 1'b1);
        sw = 8'hFB;
        cyc(4);
        pulse(don);
        check("readout", {ann, ro}, 4'h2);
        sw = 8'hFF;
        cyc(4);
        cal_try(1, 0, 1, 3'b100);
        cal_try(1, 0, 0, 3'b001);
        cal_try(0, 1, 0, 3'b001);
        sw = 8'hF7;
        cyc(4);
        cal_try(0, 1, 0, 3'b010);
        cal_try(1, 1, 1, 3'b011);
        sw = 8'hE7;
        cyc(4);
        cal_try(1, 0, 1, 3'b001);
        sw = 8'hEF;
        cyc(4);
        cal_try(0, 1, 1, 3'b001);
        sw = 8'hDF;
        rst_in = 1;
        cyc(3);
        rst_in = 0;
        wait_valid();
        check("power_on_recall", {slot, prcl, prst}, 6'h02);
        end_of_test();
    end
endmodule // test_module_config_switch_decoder

`default_nettype wire
